// >>> src/lpst_cfg.svh
// Timing and pin constants for the long-press power switch timer.
// Assumes a 200 MHz system clock; times are converted to cycle counts here.
`ifndef LPST_CFG_SVH
`define LPST_CFG_SVH

// System clock rate
`define CLOCK_MHZ           200

// Hold delay before the enable output rises, nominal
`define HOLD_DELAY_MS       64'd8000
`define HOLD_CYCLES_DEF     (`HOLD_DELAY_MS * 64'd1000 * `CLOCK_MHZ)

// Longest window in which the test edges must arrive
`define TEST_ENTRY_WINDOW_NS 35000
`define TEST_WINDOW_CYCLES_DEF (`TEST_ENTRY_WINDOW_NS * `CLOCK_MHZ / 1000)

// Short delay from test entry to enable, typical
`define TEST_DELAY_NS       250000
`define TEST_DELAY_CYCLES_DEF (`TEST_DELAY_NS * `CLOCK_MHZ / 1000)

// Rising charger edges that select the test mode
`define TEST_EDGES          7

// Level read from an undriven pin
`define BUTTON_IDLE_LEVEL   1'b1
`define CHARGER_IDLE_LEVEL  1'b0

`endif

// >>> src/lpst_pkg.sv
// Types shared by the power switch timer and its pin conditioner.
// Assumes the constants header is compiled alongside.
package lpst_pkg;

  // Conditioned pin: level and one-cycle edge pulses
  typedef struct packed {
    logic level;
    logic rose;
    logic fell;
  } pin_t;

  typedef enum logic [1:0] {
    st_idle,
    st_hold,
    st_test,
    st_on
  } state_t;

  typedef struct packed {
    state_t      st;
    logic [31:0] cnt;
    logic [31:0] win;
    logic [2:0]  edges;
    logic        enable;
    logic        started;
  } ctl_t;

endpackage

// >>> src/pin_conditioner.sv
// Samples one input pin, substitutes the weak-pull level when undriven,
// and flags edges. Assumes the pin is synchronous to clock.
`timescale 1ns/1ps
`default_nettype none

module pin_conditioner #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic          pin,
  input  wire logic          driven,
  output var lpst_pkg::pin_t cond
);
  import lpst_pkg::*;

  typedef struct packed {
    logic level;
    logic prev;
  } pin_state_t;

  pin_state_t cur_q;
  pin_state_t nxt_d;

  always_comb begin
    nxt_d       = cur_q;
    nxt_d.prev  = cur_q.level;
    nxt_d.level = driven ? pin : IDLE_LEVEL;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur_q <= {IDLE_LEVEL, IDLE_LEVEL};
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign cond.level = cur_q.level;
  assign cond.rose  = cur_q.level & ~cur_q.prev;
  assign cond.fell  = ~cur_q.level & cur_q.prev;

endmodule

`default_nettype wire

// >>> src/long_press_power_switch_timer.sv
// Long-press power switch timer: hold timer, test mode and enable output.
// Assumes button and charger pins arrive synchronous to clock.
// Notes on behaviour
// - Enable rises after continuous button hold delay
// - Early release clears timer; restart on next press
// - Enable stays high until button falls
// - Enable output is active high
// - Undriven charger reads low, button reads high
// - Charger rising edge also drops enable
`timescale 1ns/1ps
`default_nettype none
`include "lpst_cfg.svh"

module long_press_power_switch_timer #(
  parameter logic [31:0] HOLD_CYCLES        = 32'(`HOLD_CYCLES_DEF),
  parameter logic [31:0] TEST_WINDOW_CYCLES = 32'(`TEST_WINDOW_CYCLES_DEF),
  parameter logic [31:0] TEST_DELAY_CYCLES  = 32'(`TEST_DELAY_CYCLES_DEF)
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic power_button_n,
  input  wire logic button_driven,
  input  wire logic charger_present,
  input  wire logic charger_driven,
  output wire logic power_enable
);
  import lpst_pkg::*;

  localparam logic [2:0] LAST_EDGE = 3'(`TEST_EDGES - 1);

  pin_t btn;
  pin_t chg;
  ctl_t cur_q;
  ctl_t nxt_d;

  pin_conditioner #(
    .IDLE_LEVEL (`BUTTON_IDLE_LEVEL)
  ) u_button (
    .clock  (clock),
    .rst_b  (rst_b),
    .pin    (power_button_n),
    .driven (button_driven),
    .cond   (btn)
  );

  pin_conditioner #(
    .IDLE_LEVEL (`CHARGER_IDLE_LEVEL)
  ) u_charger (
    .clock  (clock),
    .rst_b  (rst_b),
    .pin    (charger_present),
    .driven (charger_driven),
    .cond   (chg)
  );

  always_comb begin
    nxt_d         = cur_q;
    nxt_d.started = 1'b1;
    unique case (cur_q.st)
      st_idle: begin
        nxt_d.cnt   = '0;
        nxt_d.win   = '0;
        nxt_d.edges = '0;
        if (btn.fell) begin
          nxt_d.st = st_hold;
        end
      end
      st_hold: begin
        if (btn.rose) begin
          nxt_d.st  = st_idle;
          nxt_d.cnt = '0;
        end else if (cur_q.cnt == HOLD_CYCLES - 32'd1) begin
          nxt_d.st     = st_on;
          nxt_d.enable = 1'b1;
        end else begin
          nxt_d.cnt = cur_q.cnt + 32'd1;
          if (cur_q.win < TEST_WINDOW_CYCLES) begin
            nxt_d.win = cur_q.win + 32'd1;
          end
          // Edges only count inside the entry window
          if (chg.rose && cur_q.win < TEST_WINDOW_CYCLES) begin
            if (cur_q.edges == LAST_EDGE) begin
              nxt_d.st  = st_test;
              nxt_d.cnt = '0;
            end else begin
              nxt_d.edges = cur_q.edges + 3'd1;
            end
          end
        end
      end
      st_test: begin
        if (btn.rose) begin
          nxt_d.st  = st_idle;
          nxt_d.cnt = '0;
        end else if (cur_q.cnt == TEST_DELAY_CYCLES - 32'd1) begin
          nxt_d.st     = st_on;
          nxt_d.enable = 1'b1;
        end else begin
          nxt_d.cnt = cur_q.cnt + 32'd1;
        end
      end
      st_on: begin
        if (btn.fell || chg.rose) begin
          nxt_d.st     = st_idle;
          nxt_d.enable = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign power_enable = cur_q.enable;

  // Checks on the design's own behaviour

  property p_hold_rise;
    @(posedge clock) disable iff (!rst_b)
      $rose(power_enable) && $past(cur_q.st) == st_hold
        |-> $past(cur_q.cnt) == HOLD_CYCLES - 32'd1 && !$past(btn.level);
  endproperty
  a_hold_rise: assert property (p_hold_rise)
    else $error("enable rose without a full hold");

  property p_release_clears;
    @(posedge clock) disable iff (!rst_b)
      cur_q.st == st_hold && btn.rose |=> cur_q.st == st_idle && cur_q.cnt == 32'd0
        ##1 (cur_q.st == st_idle || cur_q.st == st_hold && cur_q.cnt == 32'd0);
  endproperty
  a_release_clears: assert property (p_release_clears)
    else $error("early release did not clear the timer");

  property p_enable_holds;
    @(posedge clock) disable iff (!rst_b)
      power_enable && !btn.fell && !chg.rose |=> power_enable;
  endproperty
  a_enable_holds: assert property (p_enable_holds)
    else $error("enable dropped without a cause");

  property p_enable_state;
    @(posedge clock) disable iff (!rst_b)
      power_enable == (cur_q.st == st_on);
  endproperty
  a_enable_state: assert property (p_enable_state)
    else $error("enable does not match on state");

  property p_test_entry;
    @(posedge clock) disable iff (!rst_b)
      cur_q.st == st_hold && !btn.rose && cur_q.cnt != HOLD_CYCLES - 32'd1
        && chg.rose && cur_q.edges == LAST_EDGE && cur_q.win < TEST_WINDOW_CYCLES
        |=> cur_q.st == st_test && !power_enable;
  endproperty
  a_test_entry: assert property (p_test_entry)
    else $error("seventh edge did not enter test mode");

  property p_test_rise;
    @(posedge clock) disable iff (!rst_b)
      $rose(power_enable) && $past(cur_q.st) == st_test
        |-> $past(cur_q.cnt) == TEST_DELAY_CYCLES - 32'd1;
  endproperty
  a_test_rise: assert property (p_test_rise)
    else $error("test delay length wrong");

  property p_idle_levels;
    @(posedge clock) disable iff (!rst_b)
      !button_driven && !charger_driven |=> btn.level && !chg.level;
  endproperty
  a_idle_levels: assert property (p_idle_levels)
    else $error("undriven pins read wrong level");

  property p_charger_drop;
    @(posedge clock) disable iff (!rst_b)
      power_enable && chg.rose |=> !power_enable && cur_q.st == st_idle
        ##1 (cur_q.st == st_idle || cur_q.st == st_hold && cur_q.cnt == 32'd0);
  endproperty
  a_charger_drop: assert property (p_charger_drop)
    else $error("charger edge did not drop enable");

  property p_button_drop;
    @(posedge clock) disable iff (!rst_b)
      power_enable && btn.fell |=> !power_enable && cur_q.st == st_idle;
  endproperty
  a_button_drop: assert property (p_button_drop)
    else $error("button press did not drop enable");

  property p_hold_count;
    @(posedge clock) disable iff (!rst_b)
      cur_q.st == st_hold && !btn.rose && !chg.rose && cur_q.cnt != HOLD_CYCLES - 32'd1
        |=> cur_q.st == st_hold && cur_q.cnt == $past(cur_q.cnt) + 32'd1;
  endproperty
  a_hold_count: assert property (p_hold_count)
    else $error("hold timer did not advance");

  property p_start_low;
    @(posedge clock) disable iff (!rst_b)
      !cur_q.started |-> !power_enable && cur_q.cnt == 32'd0;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("enable or timer not clear after reset");

  c_hold_on: cover property (@(posedge clock) disable iff (!rst_b)
    cur_q.st == st_hold ##1 cur_q.st == st_on);
  c_test_on: cover property (@(posedge clock) disable iff (!rst_b)
    cur_q.st == st_test ##1 cur_q.st == st_on);
  c_early_release: cover property (@(posedge clock) disable iff (!rst_b)
    cur_q.st == st_hold && btn.rose);
  c_charger_off: cover property (@(posedge clock) disable iff (!rst_b)
    power_enable && chg.rose);
  c_button_off: cover property (@(posedge clock) disable iff (!rst_b)
    power_enable && btn.fell);

endmodule

`default_nettype wire

// >>> tb/button_charger_model.sv
// Far side of the timer: push button and charger line.
// Assumes the timer samples both pins on the same rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module button_charger_model (
  input  wire logic clock,
  output var  logic power_button_n,
  output var  logic button_driven,
  output var  logic charger_present,
  output var  logic charger_driven
);
  // Released pins show the level opposite to their pull
  initial begin
    power_button_n  = 1'b0;
    button_driven   = 1'b0;
    charger_present = 1'b1;
    charger_driven  = 1'b0;
  end
  task automatic press_button();
    @(posedge clock);
    power_button_n <= 1'b0;
    button_driven  <= 1'b1;
  endtask
  task automatic release_button();
    @(posedge clock);
    button_driven <= 1'b0;
  endtask
  // Two cycles high, two low, then line released
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      charger_present <= 1'b1;
      charger_driven  <= 1'b1;
      repeat (2) @(posedge clock);
      charger_present <= 1'b0;
      @(posedge clock);
    end
    @(posedge clock);
    charger_present <= 1'b1;
    charger_driven  <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Bench for the long-press power switch timer with shortened counts.
// Assumes the far-side model drives both pins on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int HOLD = 200;
  localparam int DLY  = 20;
  typedef struct {int d; logic on; logic by_chg;} row_t;
  row_t rows [4] = '{'{HOLD-2, 1'b0, 1'b0}, '{HOLD+1, 1'b1, 1'b0},
                     '{HOLD+1, 1'b1, 1'b1}, '{5, 1'b0, 1'b0}};
  logic      clock = 1'b0;
  logic      rst_b = 1'b0;
  wire logic btn, btn_drv, chg, chg_drv, power_enable;
  int        n_fail = 0;
  int        total_checks = 0;
  always #2.5 clock = ~clock;
  button_charger_model i_button_charger_model (.clock(clock), .power_button_n(btn),
    .button_driven(btn_drv), .charger_present(chg), .charger_driven(chg_drv));
  long_press_power_switch_timer #(.HOLD_CYCLES(32'(HOLD)), .TEST_WINDOW_CYCLES(32'd50),
    .TEST_DELAY_CYCLES(32'(DLY))) i_long_press_power_switch_timer (.clock(clock),
    .rst_b(rst_b), .power_button_n(btn), .button_driven(btn_drv),
    .charger_present(chg), .charger_driven(chg_drv), .power_enable(power_enable));
  task automatic check_enable(input logic exp, input string what);
    #1;
    total_checks++;
    if (power_enable !== exp) begin
      n_fail++;
      $display("ERROR %0t: %s, enable %b", $time, what, power_enable);
    end
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    wait_cycles(11);
    check_enable(1'b0, "in reset");
    wait_cycles(1);
    rst_b <= 1'b1;
    wait_cycles(HOLD+5);
    check_enable(1'b0, "idle pins");
    $display("test reset done");
    foreach (rows[i]) begin
      i_button_charger_model.press_button();
      wait_cycles(rows[i].d);
      check_enable(1'b0, "before hold end");
      i_button_charger_model.release_button();
      wait_cycles(4);
      check_enable(rows[i].on, "after release");
      if (rows[i].on && rows[i].by_chg) begin
        i_button_charger_model.pulses(1);
        check_enable(1'b0, "charger off");
      end else if (rows[i].on) begin
        i_button_charger_model.press_button();
        wait_cycles(3);
        check_enable(1'b0, "button off");
        i_button_charger_model.release_button();
      end
      wait_cycles(4);
      $display("test row %0d done", i);
    end
    i_button_charger_model.press_button();
    wait_cycles(HOLD/2);
    i_button_charger_model.release_button();
    wait_cycles(3);
    i_button_charger_model.press_button();
    wait_cycles(HOLD-10);
    check_enable(1'b0, "restart count");
    wait_cycles(12);
    check_enable(1'b1, "restart on");
    i_button_charger_model.pulses(1);
    check_enable(1'b0, "restart off");
    i_button_charger_model.release_button();
    $display("test restart done");
    for (int n = 7; n >= 6; n--) begin
      i_button_charger_model.press_button();
      wait_cycles(3);
      i_button_charger_model.pulses(n);
      wait_cycles(DLY-4);
      check_enable(1'b0, "test delay");
      wait_cycles(3);
      check_enable(n == 7, "test on");
      i_button_charger_model.release_button();
      wait_cycles(3);
      check_enable(n == 7, "on after release");
      i_button_charger_model.pulses(1);
      check_enable(1'b0, "test off");
      $display("test mode %0d edges done", n);
    end
    i_button_charger_model.press_button();
    wait_cycles(HOLD+3);
    check_enable(1'b1, "on before reset");
    wait_cycles(1);
    rst_b <= 1'b0;
    wait_cycles(1);
    check_enable(1'b0, "in mid-run reset");
    i_button_charger_model.release_button();
    wait_cycles(2);
    rst_b <= 1'b1;
    wait_cycles(HOLD+5);
    check_enable(1'b0, "after mid-run reset");
    $display("test mid-run reset done");
    print_verdict();
  end
  initial begin
    wait_cycles(4000);
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
